/* File: rtl/pdus_pkg.sv */
//==============================================================
package pdus_pkg;

	// ==============================================================
	// timing
	localparam int unsigned CORE_CLK_HZ = 50_000_000;
	localparam int unsigned SYNC_DIVIDE = 4;

	// ==============================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL_ONE    = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO    = 8'h04;
	localparam logic [7:0] ADDR_STATUS      = 8'h08;
	localparam logic [7:0] ADDR_ACTIVE_ONE  = 8'h0C;
	localparam logic [7:0] ADDR_ACTIVE_TWO  = 8'h10;

	localparam logic [31:0] CTRL_ONE_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_TWO_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_ONE_WMASK  = 32'h00E0_00F8;
	localparam logic [31:0] CTRL_TWO_WMASK  = 32'h0000_0E00;

	// control_function_reg_one field layout, msb first
	typedef struct packed {
		logic [7:0]  rsv_hi;
		logic        auto_sync;
		logic        soft_manual_sync;
		logic        linear_sweep_en;
		logic [12:0] rsv_mid;
		logic        pd_digital;
		logic        pd_comparator;
		logic        pd_dac;
		logic        pd_clock_input;
		logic        pd_full_mode;
		logic [2:0]  rsv_lo;
	} pdus_ctrl_one_t;

	// control_function_reg_two field layout, msb first
	typedef struct packed {
		logic [19:0] rsv_hi;
		logic        hs_sync_enh;
		logic        hard_manual_sync;
		logic        crystal_out_active;
		logic [8:0]  rsv_lo;
	} pdus_ctrl_two_t;

	typedef struct packed {
		logic digital;
		logic comparator;
		logic dac;
		logic clock_input;
	} pdus_pd_t;

	// divider phase; sync clock is high in PH_0 and PH_1
	typedef enum logic [1:0] {
		PH_0 = 2'b00,
		PH_1 = 2'b01,
		PH_2 = 2'b10,
		PH_3 = 2'b11
	} pdus_phase_t;

	// phase a slave must be in when the master's sync clock edge is seen
	localparam pdus_phase_t SYNC_ALIGN_PH = PH_0;
	// phase that goes straight to PH_0, skipping PH_3, when an advance is pending
	localparam pdus_phase_t SHORTEN_PH    = PH_2;
	// reset in the last low phase so the first edge after reset is a true sync rise
	localparam pdus_phase_t PHASE_RESET   = PH_3;

	// status register layout, msb first
	typedef struct packed {
		logic [15:0] rsv;
		logic [7:0]  load_count;
		logic        profile_select_low;
		logic        advance_pending;
		logic [1:0]  phase;
		pdus_pd_t    pd;
	} pdus_status_t;

endpackage

/* File: rtl/pdus_ctrl.sv */
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module pdus_ctrl import pdus_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        external_powerdown_pin,
	input  wire logic        io_update,
	input  wire logic        sync_in,
	input  wire logic        profile_select_low,
	input  wire logic        crystal_osc_in,
	output logic             sync_clk_out,
	output logic             register_load,
	output pdus_pd_t         powerdown,
	output logic             crystal_out,
	output logic             hs_sync_enable,
	output logic             linear_sweep_enable
);

	// ==============================================================
	// helpers
	function automatic logic is_rise(input logic now_v, input logic prev_v);
		is_rise = now_v & ~prev_v;
	endfunction

	// ==============================================================
	// state
	pdus_ctrl_one_t buf_one_q;
	pdus_ctrl_two_t buf_two_q;
	pdus_ctrl_one_t act_one_q;
	pdus_ctrl_two_t act_two_q;
	pdus_phase_t    phase_q;
	pdus_phase_t    phase_d;
	logic           adv_q;
	logic           adv_set;
	logic           sync_in_q;
	logic           sync_rise;
	logic           upd_smp_q;
	logic           load_q;
	logic           tick;
	logic [7:0]     load_count_q;
	logic           ps_low_q;
	logic           sync_clk_q;
	pdus_pd_t       pd_q;
	pdus_pd_t       pd_d;
	logic           xtal_q;
	logic [31:0]    prdata_q;
	logic           pready_q;
	logic           pslverr_q;
	logic           setup_ph;
	logic           wr_acc;
	logic           addr_ok;
	logic [31:0]    rd_mux;
	pdus_status_t   status;

	// ==============================================================
	// apb slave: zero wait states, ready in the cycle after setup
	assign setup_ph = psel & ~penable;
	// an error response also blocks the write, so unmapped offsets never alias
	assign wr_acc   = psel & penable & pready_q & pwrite & ~pslverr_q;

	always_comb begin
		addr_ok = 1'b1;
		rd_mux  = 32'h0000_0000;
		unique case (paddr)
			ADDR_CTRL_ONE:   rd_mux = buf_one_q;
			ADDR_CTRL_TWO:   rd_mux = buf_two_q;
			ADDR_STATUS:     rd_mux = status;
			ADDR_ACTIVE_ONE: rd_mux = act_one_q;
			ADDR_ACTIVE_TWO: rd_mux = act_two_q;
			default:         addr_ok = 1'b0;
		endcase
	end

	// read-only view of divider, advance and power-down state for bring-up
	always_comb begin
		status                    = '0;
		status.load_count         = load_count_q;
		status.profile_select_low = ps_low_q;
		status.advance_pending    = adv_q;
		status.phase              = phase_q;
		status.pd                 = pd_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup_ph;
			pslverr_q <= setup_ph & ~addr_ok;
			if (setup_ph && !pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// writes land in the buffer only; the active copy waits for a load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_one_q <= CTRL_ONE_RESET;
			buf_two_q <= CTRL_TWO_RESET;
		end else if (wr_acc) begin
			if (paddr == ADDR_CTRL_ONE) begin
				buf_one_q <= pwdata & CTRL_ONE_WMASK;
			end
			if (paddr == ADDR_CTRL_TWO) begin
				buf_two_q <= pwdata & CTRL_TWO_WMASK;
			end
		end
	end

	// ==============================================================
	// divide-by-four sync clock with one-count shortening
	always_comb begin
		unique case (phase_q)
			PH_0: phase_d = PH_1;
			PH_1: phase_d = PH_2;
			PH_2: phase_d = adv_q ? PH_0 : PH_3;
			PH_3: phase_d = PH_0;
		endcase
	end

	// rising edge of the sync clock is the edge that enters PH_0
	assign tick = (phase_d == PH_0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// low phase matches the low output, so no half period follows reset
			phase_q    <= PHASE_RESET;
			sync_clk_q <= 1'b0;
		end else begin
			phase_q    <= phase_d;
			sync_clk_q <= (phase_d == PH_0) || (phase_d == PH_1);
		end
	end

	// ==============================================================
	// edge advance requests
	// inputs are synchronous, so one register suffices for edge detection
	// the previous level resets low, the idle level of the pin, so reset makes no edge
	assign sync_rise = is_rise(sync_in, sync_in_q);

	// auto requests are held off while one is pending to avoid double steps
	assign adv_set = act_one_q.soft_manual_sync
		| (act_two_q.hard_manual_sync & sync_rise)
		| (act_one_q.auto_sync & sync_rise & ~adv_q & (phase_q != SYNC_ALIGN_PH));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_in_q <= 1'b0;
		end else begin
			sync_in_q <= sync_in;
		end
	end

	// a new request in the cycle the shortened count is used is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_q <= 1'b0;
		end else if (adv_set) begin
			adv_q <= 1'b1;
		end else if (phase_q == SHORTEN_PH) begin
			adv_q <= 1'b0;
		end
	end

	// ==============================================================
	// update strobe sampling and load pulse
	// the profile pin has no path into the load; only the strobe edge loads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_smp_q <= 1'b0;
			load_q    <= 1'b0;
		end else if (tick) begin
			upd_smp_q <= io_update;
			load_q    <= is_rise(io_update, upd_smp_q);
		end else begin
			load_q    <= 1'b0;
		end
	end

	// load pulse always rises with the sync clock edge; the active copy follows one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_one_q <= CTRL_ONE_RESET;
			act_two_q <= CTRL_TWO_RESET;
		end else if (load_q) begin
			act_one_q <= buf_one_q;
			act_two_q <= buf_two_q;
		end else if (act_one_q.soft_manual_sync) begin
			// one-shot: the step is taken once per load of the bit
			act_one_q.soft_manual_sync <= 1'b0;
		end
	end

	// load counter wraps; it is a debug aid only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_count_q <= 8'h00;
			ps_low_q     <= 1'b0;
		end else begin
			ps_low_q <= profile_select_low;
			if (load_q) begin
				load_count_q <= load_count_q + 8'h01;
			end
		end
	end

	// ==============================================================
	// power-down decode
	always_comb begin
		if (!external_powerdown_pin) begin
			pd_d.digital     = act_one_q.pd_digital;
			pd_d.comparator  = act_one_q.pd_comparator;
			pd_d.dac         = act_one_q.pd_dac;
			pd_d.clock_input = act_one_q.pd_clock_input;
		end else if (!act_one_q.pd_full_mode) begin
			// fast recovery: keep clocks and DAC alive; logic sleeps, comparator follows its bit
			pd_d.digital     = 1'b1;
			pd_d.comparator  = act_one_q.pd_comparator;
			pd_d.dac         = 1'b0;
			pd_d.clock_input = 1'b0;
		end else begin
			pd_d = '1;
		end
	end

	// registered so every power-down output comes straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_q   <= '0;
			xtal_q <= 1'b0;
		end else begin
			pd_q   <= pd_d;
			// registered copy; fine for a low-rate reference tap only
			xtal_q <= crystal_osc_in & act_two_q.crystal_out_active;
		end
	end

	// ==============================================================
	// outputs
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign sync_clk_out        = sync_clk_q;
	assign register_load       = load_q;
	assign powerdown           = pd_q;
	assign crystal_out         = xtal_q;
	assign hs_sync_enable      = act_two_q.hs_sync_enh;
	assign linear_sweep_enable = act_one_q.linear_sweep_en;

	// ==============================================================
	// assertions
	a_pd_software: assert property (@(posedge pclk) disable iff (!presetn)
		!external_powerdown_pin |=> powerdown == {$past(act_one_q.pd_digital), $past(act_one_q.pd_comparator),
			$past(act_one_q.pd_dac), $past(act_one_q.pd_clock_input)})
		else $error("power-down outputs do not follow software bits");

	a_pd_fast_mode: assert property (@(posedge pclk) disable iff (!presetn)
		external_powerdown_pin && !act_one_q.pd_full_mode |=> powerdown.digital && !powerdown.dac
			&& !powerdown.clock_input && (powerdown.comparator == $past(act_one_q.pd_comparator)))
		else $error("fast recovery power-down levels wrong");

	a_pd_full_mode: assert property (@(posedge pclk) disable iff (!presetn)
		external_powerdown_pin && act_one_q.pd_full_mode |=> powerdown == 4'b1111)
		else $error("full power-down not forcing all outputs");

	a_div_normal: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sync_clk_out) && !adv_q |=> !adv_q |=> !adv_q |-> ##2 $rose(sync_clk_out))
		else $error("sync clock period is not four system clocks");

	a_div_shorten: assert property (@(posedge pclk) disable iff (!presetn)
		phase_q == PH_2 && adv_q |=> phase_q == PH_0 ##0 sync_clk_out)
		else $error("advance did not shorten the count by one");

	a_load_edge: assert property (@(posedge pclk) disable iff (!presetn)
		tick && io_update && !upd_smp_q |=> register_load ##1 !register_load)
		else $error("strobe edge did not give a single load pulse");

	a_load_held: assert property (@(posedge pclk) disable iff (!presetn)
		tick && io_update && upd_smp_q |=> !register_load)
		else $error("held strobe produced another load");

	a_load_latency: assert property (@(posedge pclk) disable iff (!presetn)
		register_load |-> $past(tick) && phase_q == PH_0)
		else $error("load pulse not at fixed sync clock position");

	a_hw_advance: assert property (@(posedge pclk) disable iff (!presetn)
		act_two_q.hard_manual_sync && sync_rise |=> adv_q)
		else $error("sync input edge did not request an advance");

	a_sw_advance: assert property (@(posedge pclk) disable iff (!presetn)
		act_one_q.soft_manual_sync && !load_q |=> adv_q && !act_one_q.soft_manual_sync)
		else $error("software manual sync did not step once");

	a_crystal_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!act_two_q.crystal_out_active |=> !crystal_out)
		else $error("crystal output driven while disabled");

	// strobe sampling, buffered copy, alignment and crystal path
	a_strobe_sample: assert property (@(posedge pclk) disable iff (!presetn)
		tick |=> upd_smp_q == $past(io_update))
		else $error("update strobe not sampled at the sync clock rise");

	a_load_only_edge: assert property (@(posedge pclk) disable iff (!presetn)
		!(tick && io_update && !upd_smp_q) |=> !register_load)
		else $error("load pulse without a sampled strobe edge");

	a_active_copy: assert property (@(posedge pclk) disable iff (!presetn)
		register_load |=> act_one_q == $past(buf_one_q) && act_two_q == $past(buf_two_q))
		else $error("load did not copy the buffered settings");

	a_auto_request: assert property (@(posedge pclk) disable iff (!presetn)
		act_one_q.auto_sync && sync_rise && !adv_q && phase_q != SYNC_ALIGN_PH |=> adv_q)
		else $error("misaligned sync input did not request an advance");

	a_auto_aligned: assert property (@(posedge pclk) disable iff (!presetn)
		act_one_q.auto_sync && !act_one_q.soft_manual_sync && !act_two_q.hard_manual_sync && sync_rise && !adv_q
			&& phase_q == SYNC_ALIGN_PH |=> !adv_q)
		else $error("aligned slave still requested an advance");

	a_crystal_pass: assert property (@(posedge pclk) disable iff (!presetn)
		act_two_q.crystal_out_active |=> crystal_out == $past(crystal_osc_in))
		else $error("crystal output does not follow the oscillator");

	// cover points for the main scenarios
	c_load_seen: cover property (@(posedge pclk) disable iff (!presetn) register_load);
	c_advance_used: cover property (@(posedge pclk) disable iff (!presetn) phase_q == PH_2 && adv_q);
	c_full_pd: cover property (@(posedge pclk) disable iff (!presetn) powerdown == 4'b1111);
	c_auto_align: cover property (@(posedge pclk) disable iff (!presetn)
		act_one_q.auto_sync && sync_rise && phase_q == SYNC_ALIGN_PH);
	c_hw_step: cover property (@(posedge pclk) disable iff (!presetn) act_two_q.hard_manual_sync && sync_rise);

endmodule // pdus_ctrl

/* File: tb/pdus_host_model.sv */
`timescale 1ns/10ps
// ==============================================================
// host controller and master device driving strobe, sync and oscillator pins
module pdus_host_model import pdus_pkg::*; (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic sync_clk_out,
	output logic      io_update,
	output logic      sync_in,
	output logic      crystal_osc_in
);
	logic       master_en;
	logic       step_q;
	logic [1:0] mcnt_q;

	initial begin
		io_update = 1'b0;
		step_q    = 1'b0;
		master_en = 1'b0;
	end

	// master divider runs from the same pclk, the common clock source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mcnt_q <= 2'b00;
		else
			mcnt_q <= mcnt_q + 2'b01;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			crystal_osc_in <= 1'b0;
		else
			crystal_osc_in <= ~crystal_osc_in;
	end

	assign sync_in = master_en ? ~mcnt_q[1] : step_q;

	// raised after a falling sync edge so it is settled at the sampling rise
	task automatic update(input int rises);
		@(negedge sync_clk_out) io_update <= 1'b1;
		repeat (rises) @(posedge sync_clk_out);
		@(negedge sync_clk_out) io_update <= 1'b0;
		repeat (2) @(posedge sync_clk_out);
	endtask

	task automatic step();
		@(posedge pclk) step_q <= 1'b1;
		repeat (2) @(posedge pclk);
		step_q <= 1'b0;
		@(posedge pclk);
	endtask
endmodule // pdus_host_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
	import pdus_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        external_powerdown_pin, io_update, sync_in, profile_select_low, crystal_osc_in;
	logic        sync_clk_out, register_load, crystal_out, hs_sync_enable, linear_sweep_enable;
	pdus_pd_t    powerdown;
	int          n_errors, checked, loads, rises, r0, n;
	realtime     t0, t1;

	pdus_ctrl dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.external_powerdown_pin, .io_update, .sync_in, .profile_select_low, .crystal_osc_in, .sync_clk_out,
		.register_load, .powerdown, .crystal_out, .hs_sync_enable, .linear_sweep_enable);
	pdus_host_model host (.pclk, .presetn, .sync_clk_out, .io_update, .sync_in, .crystal_osc_in);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk) if (register_load === 1'b1) loads++;
	always @(posedge sync_clk_out) rises++;

	// ==============================================================
	// helpers
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// waits for pready at rising edges; the watchdog ends a hang
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk) penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0000_0000);
		chk("read data", exp, prdata);
		chk("slave error", {31'h0, err}, {31'h0, pslverr});
	endtask

	task automatic load(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		host.update(1);
		repeat (4) @(posedge pclk);
	endtask

	task automatic begin_span();
		@(posedge sync_clk_out);
		t0 = $realtime;
		#1;
		r0 = rises;
	endtask

	// elapsed pclk cycles over the counted sync rises, less the advances expected
	task automatic end_span(input string what, input int adv);
		repeat (2) @(posedge sync_clk_out);
		t1 = $realtime;
		#1;
		chk(what, 4 * (rises - r0) - adv, int'((t1 - t0) / 20.0));
	endtask

	task automatic xtog(input logic [31:0] exp);
		logic last;
		n    = 0;
		last = crystal_out;
		repeat (16) begin
			@(posedge pclk);
			if (crystal_out !== last) n++;
			last = crystal_out;
		end
		chk("crystal toggles", exp, n);
	endtask

	initial begin
		#1_000_000;
		n_errors++;
		close_out();
	end

	// ==============================================================
	// tests
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{external_powerdown_pin, profile_select_low} = 2'b00;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(ADDR_CTRL_ONE, CTRL_ONE_RESET, 1'b0);
		rdchk(ADDR_CTRL_TWO, CTRL_TWO_RESET, 1'b0);
		rdchk(8'h20, 32'h0000_0000, 1'b1);
		apb(1'b1, ADDR_CTRL_ONE, 32'hFFFF_FFFF);
		rdchk(ADDR_CTRL_ONE, CTRL_ONE_WMASK, 1'b0);
		rdchk(ADDR_ACTIVE_ONE, 32'h0000_0000, 1'b0);
		begin_span();
		end_span("sync period", 0);
		for (int p = 0; p < 2; p++)
			for (int m = 0; m < 2; m++)
				for (int k = 0; k < 2; k++) begin
					logic [3:0] s;
					s = k ? 4'hA : 4'h5;
					load(ADDR_CTRL_ONE, {24'h00_0000, s, m[0], 3'b000});
					external_powerdown_pin <= p[0];
					repeat (3) @(posedge pclk);
					chk("powerdown", p == 0 ? s : (m ? 4'hF : {1'b1, s[2], 2'b00}), {28'h0, powerdown});
				end
		external_powerdown_pin <= 1'b0;
		n = loads;
		host.update(4);
		chk("held strobe loads", n + 1, loads);
		load(ADDR_CTRL_ONE, 32'h0020_0000);
		chk("sweep enable", 1, linear_sweep_enable);
		n = loads;
		repeat (6) begin
			@(posedge pclk) profile_select_low <= ~profile_select_low;
			repeat (3) @(posedge pclk);
		end
		chk("sweep pin loads", n, loads);
		apb(1'b1, ADDR_CTRL_ONE, 32'h0040_0000);
		begin_span();
		host.update(1);
		end_span("soft advance", 1);
		apb(1'b1, ADDR_CTRL_ONE, 32'h0000_0000);
		begin_span();
		host.update(1);
		end_span("plain load", 0);
		load(ADDR_CTRL_TWO, 32'h0000_0400);
		begin_span();
		host.step();
		end_span("hard advance", 1);
		xtog(0);
		load(ADDR_CTRL_TWO, 32'h0000_0200);
		xtog(16);
		load(ADDR_CTRL_TWO, 32'h0000_0A00);
		chk("hs enhance", 1, hs_sync_enable);
		rdchk(ADDR_ACTIVE_TWO, 32'h0000_0A00, 1'b0);
		load(ADDR_CTRL_ONE, 32'h0080_0000);
		@(posedge pclk) host.master_en <= 1'b1;
		repeat (100) @(posedge pclk);
		begin_span();
		chk("auto phase", 0, host.mcnt_q);
		repeat (6) @(posedge sync_clk_out);
		end_span("auto locked", 0);
		apb(1'b0, ADDR_STATUS, 32'h0000_0000);
		chk("load count", loads[7:0], prdata[15:8]);
		chk("status power-down", 32'h0000_0000, prdata[3:0]);
		close_out();
	end
endmodule // testbench
